// ==== hdl/ccsr_core_state.sv ====
// Architectural state of an 8-bit core: fetch, register file, pointers,
// status flags, stack pointer and interrupt choice.
// Assumes decoder, ALU and memories run on sys_clk; program memory
// answers pm_addr in the same cycle.
`timescale 1ns/1ps
module ccsr_core_state #(
  parameter int unsigned IRQ_NUM = 8,
  parameter int unsigned SP_BITS = 16,
  parameter logic [15:0] SRAM_LAST = 16'h0FFF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Program memory and fetch control
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  input wire logic fetch_hold,
  input wire logic pc_load,
  input wire logic [15:0] pc_target,
  output logic [15:0] instr_word,
  output logic instr_valid,
  // Register file ports
  input wire ccsr_pkg::ccsr_rd_req_t rd_req,
  input wire ccsr_pkg::ccsr_wr_req_t wr_req,
  input wire ccsr_pkg::ccsr_flag_upd_t flag_upd,
  output logic [15:0] opnd_a,
  output logic [7:0] opnd_b,
  // Pointer requests
  input wire ccsr_pkg::ccsr_ptr_req_t ptr_req,
  output logic [15:0] ptr_addr,
  output logic ptr_valid,
  // Data-space access
  input wire ccsr_pkg::ccsr_ds_req_t ds_req,
  output logic [7:0] ds_rdata,
  output logic ds_ack,
  output logic fwd_en,
  output logic fwd_we,
  output logic [15:0] fwd_addr,
  output logic [7:0] fwd_wdata,
  // Control operations and interrupts
  input wire ccsr_pkg::ccsr_ctl_req_t ctl_req,
  input wire logic [IRQ_NUM-1:0] irq_req,
  input wire logic irq_ok,
  output logic irq_take,
  output logic [4:0] irq_vec,
  output logic [7:0] status_flags,
  output logic [15:0] stack_top_pointer,
  // Stack memory requests
  output logic stk_we,
  output logic stk_re,
  output logic stk_two,
  output logic [15:0] stk_addr,
  output logic [15:0] stk_wdata
);
  import ccsr_pkg::*;

  if (SP_BITS < 8 || SP_BITS > 16 || IRQ_NUM < 1 || IRQ_NUM > 32) begin
    $error("ccsr_core_state: SP_BITS or IRQ_NUM out of range");
  end

  function automatic ccsr_region_t region_of(input logic [15:0] a);
    if (a <= ADDR_RF_LAST) begin
      region_of = RG_RF;
    end else if (a == ADDR_STATUS || a == ADDR_STK_LO ||
                 a == ADDR_STK_HI) begin
      region_of = RG_CORE;
    end else begin
      region_of = RG_FWD;
    end
  endfunction

  function automatic logic [4:0] first_set(input logic [IRQ_NUM-1:0] v);
    first_set = 5'h00;
    for (int i = IRQ_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  logic [15:0] pc_ff, instr_ff;
  logic instr_vld_ff;
  logic [7:0] rf_ff [RF_DEPTH];
  logic [7:0] nxt_rf [RF_DEPTH];
  logic [15:0] opa_ff;
  logic [7:0] opb_ff;
  logic [7:0] status_ff, nxt_status;
  logic [SP_BITS-1:0] sp_ff, nxt_sp;
  logic [15:0] sp16, ds_eff, ptr_cur, ptr_new, ptr_ea;
  logic [4:0] ptr_lo;
  logic ds_rf_we, ds_core_we, ptr_step, take_now;
  ccsr_region_t ds_rg;
  logic [15:0] ptr_addr_ff;
  logic ptr_vld_ff;
  logic [7:0] ds_rdata_ff, fwd_wdata_ff;
  logic ds_ack_ff, fwd_en_ff, fwd_we_ff;
  logic [15:0] fwd_addr_ff;
  logic irq_take_ff;
  logic [4:0] irq_vec_ff;
  logic stk_we_ff, stk_re_ff, stk_two_ff;
  logic [15:0] stk_addr_ff, stk_wdata_ff;

  // Single-stage prefetch; a load flushes the word already fetched
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_ff <= PC_RST;
      instr_ff <= 16'h0000;
      instr_vld_ff <= 1'b0;
    end else if (pc_load) begin
      pc_ff <= pc_target;
      instr_vld_ff <= 1'b0;
    end else if (!fetch_hold) begin
      pc_ff <= pc_ff + 16'h0001;
      instr_ff <= pm_rdata;
      instr_vld_ff <= 1'b1;
    end
  end

  // I/O instructions carry a 6-bit address, so they can never
  // reach past 0x5F into the extended region
  assign ds_eff = ds_req.io ?
    ADDR_IO_BASE + {10'h000, ds_req.addr[5:0]} : ds_req.addr;
  assign ds_rg = region_of(ds_eff);
  assign ds_rf_we = ds_req.en && ds_req.we && ds_rg == RG_RF;
  assign ds_core_we = ds_req.en && ds_req.we && ds_rg == RG_CORE;

  // Pointer pair: even register low byte, odd register high byte
  assign ptr_lo = ADDR_PTR_BASE + {2'b00, ptr_req.sel, 1'b0};
  assign ptr_cur = {rf_ff[ptr_lo | 5'h01], rf_ff[ptr_lo]};
  assign ptr_step = ptr_req.en && ptr_req.sel != 2'b11 &&
    ptr_req.mode != PM_DISP;

  always_comb begin
    ptr_new = ptr_cur;
    ptr_ea = ptr_cur + {10'h000, ptr_req.disp};
    if (ptr_req.mode == PM_INC) begin
      ptr_new = ptr_cur + 16'h0001;
      ptr_ea = ptr_cur;
    end else if (ptr_req.mode == PM_DEC) begin
      ptr_new = ptr_cur - 16'h0001;
      ptr_ea = ptr_new;
    end
  end

  // Later writers win: data space, pointer step, bit load, ALU result
  always_comb begin
    nxt_rf = rf_ff;
    if (ds_rf_we) begin
      nxt_rf[ds_eff[4:0]] = ds_req.wdata;
    end
    if (ptr_step) begin
      nxt_rf[ptr_lo] = ptr_new[7:0];
      nxt_rf[ptr_lo | 5'h01] = ptr_new[15:8];
    end
    if (ctl_req.op == OP_BIT_LOAD) begin
      nxt_rf[ctl_req.reg_idx][ctl_req.bit_idx] = status_ff[BIT_COPY];
    end
    if (wr_req.en && wr_req.wide) begin
      nxt_rf[{wr_req.idx[4:1], 1'b0}] = wr_req.data[7:0];
      nxt_rf[{wr_req.idx[4:1], 1'b1}] = wr_req.data[15:8];
    end else if (wr_req.en) begin
      nxt_rf[wr_req.idx] = wr_req.data[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < RF_DEPTH; i++) begin
        rf_ff[i] <= 8'h00;
      end
    end else begin
      rf_ff <= nxt_rf;
    end
  end

  // Operands read the post-write view, so back-to-back ops see results
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opa_ff <= 16'h0000;
      opb_ff <= 8'h00;
    end else begin
      opb_ff <= nxt_rf[rd_req.b_idx];
      if (rd_req.wide) begin
        opa_ff <= {nxt_rf[{rd_req.a_idx[4:1], 1'b1}],
                   nxt_rf[{rd_req.a_idx[4:1], 1'b0}]};
      end else begin
        opa_ff <= {8'h00, nxt_rf[rd_req.a_idx]};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_addr_ff <= 16'h0000;
      ptr_vld_ff <= 1'b0;
    end else begin
      ptr_addr_ff <= ptr_ea;
      ptr_vld_ff <= ptr_req.en && ptr_req.sel != 2'b11;
    end
  end

  // Interrupt gate; the decoder raises irq_ok only on a free slot
  assign take_now = irq_ok && status_ff[BIT_IEN] && (|irq_req) &&
    ctl_req.op == OP_NONE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_take_ff <= 1'b0;
      irq_vec_ff <= 5'h00;
    end else begin
      irq_take_ff <= take_now;
      if (take_now) begin
        irq_vec_ff <= first_set(irq_req);
      end
    end
  end

  // Status: bus write, then ALU flags, then control ops. No save on
  // entry and none on return: handlers must keep it themselves.
  always_comb begin
    nxt_status = status_ff;
    if (ds_core_we && ds_eff == ADDR_STATUS) begin
      nxt_status = ds_req.wdata;
    end
    nxt_status = (nxt_status & ~flag_upd.mask) |
      (flag_upd.val & flag_upd.mask);
    case (ctl_req.op)
      OP_IEN_SET, OP_RETURN_FROM_IRQ_OP: nxt_status[BIT_IEN] = 1'b1;
      OP_IEN_CLR: nxt_status[BIT_IEN] = 1'b0;
      OP_BIT_STORE: nxt_status[BIT_COPY] =
        rf_ff[ctl_req.reg_idx][ctl_req.bit_idx];
      default: ;
    endcase
    if (take_now) begin
      nxt_status[BIT_IEN] = 1'b0;
    end
    // Sign is never stored on its own, so it cannot disagree
    nxt_status[BIT_SIGN] = nxt_status[BIT_NEG] ^ nxt_status[BIT_OVF];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Narrow stack pointer: written bits at and above SP_BITS fall away, and those bits read as zero
  assign sp16 = 16'(sp_ff);

  always_comb begin
    nxt_sp = sp_ff;
    if (ds_core_we && ds_eff == ADDR_STK_LO) begin
      nxt_sp = SP_BITS'({sp16[15:8], ds_req.wdata});
    end else if (ds_core_we && ds_eff == ADDR_STK_HI) begin
      nxt_sp = SP_BITS'({ds_req.wdata, sp16[7:0]});
    end
    case (ctl_req.op)
      OP_PUSH: nxt_sp = sp_ff - SP_BITS'(STEP_DATA);
      OP_POP: nxt_sp = sp_ff + SP_BITS'(STEP_DATA);
      OP_CALL: nxt_sp = sp_ff - SP_BITS'(STEP_RET);
      OP_RET, OP_RETURN_FROM_IRQ_OP: nxt_sp = sp_ff + SP_BITS'(STEP_RET);
      default: ;
    endcase
    if (take_now) begin
      nxt_sp = sp_ff - SP_BITS'(STEP_RET);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp_ff <= SP_BITS'(SRAM_LAST);
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  // Stack memory request: writes put the low byte at stk_addr, high byte one below; two-byte reads address the high byte, low one above
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stk_we_ff <= 1'b0;
      stk_re_ff <= 1'b0;
      stk_two_ff <= 1'b0;
      stk_addr_ff <= 16'h0000;
      stk_wdata_ff <= 16'h0000;
    end else begin
      stk_we_ff <= take_now || ctl_req.op == OP_PUSH ||
        ctl_req.op == OP_CALL;
      stk_re_ff <= ctl_req.op == OP_POP || ctl_req.op == OP_RET ||
        ctl_req.op == OP_RETURN_FROM_IRQ_OP;
      stk_two_ff <= take_now || ctl_req.op == OP_CALL ||
        ctl_req.op == OP_RET || ctl_req.op == OP_RETURN_FROM_IRQ_OP;
      // Taken from the current sp_ff, so a push right after a pop writes at the raised top
      stk_addr_ff <= (ctl_req.op == OP_POP || ctl_req.op == OP_RET ||
        ctl_req.op == OP_RETURN_FROM_IRQ_OP) ? sp16 + STEP_DATA : sp16;
      stk_wdata_ff <= ctl_req.op == OP_PUSH ?
        {8'h00, rf_ff[ctl_req.reg_idx]} : ctl_req.ret_pc;
    end
  end

  // Data-space answer; anything the core does not own goes outward
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ds_rdata_ff <= 8'h00;
      ds_ack_ff <= 1'b0;
      fwd_en_ff <= 1'b0;
      fwd_we_ff <= 1'b0;
      fwd_addr_ff <= 16'h0000;
      fwd_wdata_ff <= 8'h00;
    end else begin
      ds_ack_ff <= ds_req.en && ds_rg != RG_FWD;
      fwd_en_ff <= ds_req.en && ds_rg == RG_FWD;
      fwd_we_ff <= ds_req.we;
      fwd_addr_ff <= ds_eff;
      fwd_wdata_ff <= ds_req.wdata;
      if (ds_rg == RG_RF) begin
        ds_rdata_ff <= rf_ff[ds_eff[4:0]];
      end else if (ds_eff == ADDR_STATUS) begin
        ds_rdata_ff <= status_ff;
      end else if (ds_eff == ADDR_STK_LO) begin
        ds_rdata_ff <= sp16[7:0];
      end else begin
        ds_rdata_ff <= sp16[15:8];
      end
    end
  end

  assign pm_addr = pc_ff;
  assign instr_word = instr_ff;
  assign instr_valid = instr_vld_ff;
  assign opnd_a = opa_ff;
  assign opnd_b = opb_ff;
  assign ptr_addr = ptr_addr_ff;
  assign ptr_valid = ptr_vld_ff;
  assign ds_rdata = ds_rdata_ff;
  assign ds_ack = ds_ack_ff;
  assign fwd_en = fwd_en_ff;
  assign fwd_we = fwd_we_ff;
  assign fwd_addr = fwd_addr_ff;
  assign fwd_wdata = fwd_wdata_ff;
  assign irq_take = irq_take_ff;
  assign irq_vec = irq_vec_ff;
  assign status_flags = status_ff;
  assign stack_top_pointer = sp16;
  assign stk_we = stk_we_ff;
  assign stk_re = stk_re_ff;
  assign stk_two = stk_two_ff;
  assign stk_addr = stk_addr_ff;
  assign stk_wdata = stk_wdata_ff;

  sign_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_ff[BIT_SIGN] == (status_ff[BIT_NEG] ^ status_ff[BIT_OVF]))
    else $error("sign flag differs from negative xor overflow");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    irq_take_ff |-> $past(status_ff[BIT_IEN]))
    else $error("interrupt taken while globally disabled");
  irq_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    take_now |=> irq_take_ff && !status_ff[BIT_IEN])
    else $error("enable not cleared on interrupt entry");
  irq_prio_a: assert property (@(posedge sys_clk) disable iff (rst)
    take_now && irq_req[0] |=> irq_vec_ff == 5'h00)
    else $error("lowest pending vector not chosen");
  fetch_step_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && !pc_load && !fetch_hold |=> pc_ff == $past(pc_ff) + 16'h0001 &&
    instr_ff == $past(pm_rdata) && instr_vld_ff)
    else $error("prefetch did not advance");
  rf_bypass_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_req.en && !wr_req.wide && !rd_req.wide &&
    rd_req.a_idx == wr_req.idx |=> opa_ff == {8'h00, $past(wr_req.data[7:0])})
    else $error("written result not seen as operand");
  push_step_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctl_req.op == OP_PUSH |=> stk_we_ff && !stk_two_ff &&
    sp_ff == $past(sp_ff) - SP_BITS'(STEP_DATA))
    else $error("push did not lower stack pointer by one");
  call_step_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctl_req.op == OP_CALL |=> stk_we_ff && stk_two_ff &&
    sp_ff == $past(sp_ff) - SP_BITS'(STEP_RET))
    else $error("call did not lower stack pointer by two");
  ptr_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    ptr_step && ptr_req.mode == PM_INC && !wr_req.en &&
    ctl_req.op != OP_BIT_LOAD && ptr_cur == 16'hFFFF |=>
    rf_ff[$past(ptr_lo)] == 8'h00 && ptr_addr_ff == 16'hFFFF)
    else $error("pointer increment did not wrap");
endmodule // ccsr_core_state

// ==== pkg/ccsr_pkg.sv ====
// Constants, field layouts and request carriers of the core state block.
// Assumes one clock domain; every carrier is driven by same-clock logic.
package ccsr_pkg;
  localparam int unsigned RF_DEPTH = 32;
  localparam logic [15:0] ADDR_RF_LAST = 16'h001F;
  localparam logic [15:0] ADDR_IO_BASE = 16'h0020;
  localparam logic [4:0] ADDR_PTR_BASE = 5'h1A;
  localparam logic [15:0] ADDR_STK_LO = 16'h005D;
  localparam logic [15:0] ADDR_STK_HI = 16'h005E;
  localparam logic [15:0] ADDR_STATUS = 16'h005F;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam int unsigned BIT_IEN = 7;
  localparam int unsigned BIT_COPY = 6;
  localparam int unsigned BIT_HALF = 5;
  localparam int unsigned BIT_SIGN = 4;
  localparam int unsigned BIT_OVF = 3;
  localparam int unsigned BIT_NEG = 2;
  localparam int unsigned BIT_ZERO = 1;
  localparam int unsigned BIT_CARRY = 0;
  localparam logic [15:0] STEP_DATA = 16'h0001;
  localparam logic [15:0] STEP_RET = 16'h0002;
  localparam logic [15:0] PC_RST = 16'h0000;

  typedef enum logic [3:0] {
    OP_NONE, OP_IEN_SET, OP_IEN_CLR, OP_BIT_STORE, OP_BIT_LOAD,
    OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_RETURN_FROM_IRQ_OP
  } ccsr_op_t;
  typedef enum logic [1:0] {
    PM_DISP = 2'b00, PM_INC = 2'b01, PM_DEC = 2'b11
  } ccsr_pmode_t;
  typedef enum logic [1:0] {RG_RF, RG_CORE, RG_FWD} ccsr_region_t;

  typedef struct packed {
    logic [4:0] a_idx;
    logic [4:0] b_idx;
    logic wide;
  } ccsr_rd_req_t;
  typedef struct packed {
    logic en;
    logic wide;
    logic [4:0] idx;
    logic [15:0] data;
  } ccsr_wr_req_t;
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] val;
  } ccsr_flag_upd_t;
  typedef struct packed {
    logic en;
    logic we;
    logic io;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ccsr_ds_req_t;
  typedef struct packed {
    logic en;
    logic [1:0] sel;
    ccsr_pmode_t mode;
    logic [5:0] disp;
  } ccsr_ptr_req_t;
  typedef struct packed {
    ccsr_op_t op;
    logic [4:0] reg_idx;
    logic [2:0] bit_idx;
    logic [15:0] ret_pc;
  } ccsr_ctl_req_t;
endpackage

// ==== dv/ccsr_far_mem.sv ====
// Far-side model: program memory and data SRAM behind the core state block.
// Assumes stack and forwarded requests arrive as one-cycle pulses on sys_clk.
`timescale 1ns/1ps
module ccsr_far_mem (
  // Clock
  input wire logic sys_clk,
  // Program memory
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_rdata,
  // Stack and forwarded writes
  input wire logic stk_we,
  input wire logic stk_two,
  input wire logic [15:0] stk_addr,
  input wire logic [15:0] stk_wdata,
  input wire logic fwd_en,
  input wire logic fwd_we,
  input wire logic [15:0] fwd_addr,
  input wire logic [7:0] fwd_wdata
);
  logic [7:0] mem [0:65535];

  // Asynchronous read; a scramble of the address makes every word distinct
  assign pm_rdata = pm_addr ^ 16'hC3C3;

  // Return addresses land low byte first, high byte one below
  always_ff @(posedge sys_clk) begin
    if (stk_we) begin
      mem[stk_addr] <= stk_wdata[7:0];
      if (stk_two) begin
        mem[stk_addr - 16'h0001] <= stk_wdata[15:8];
      end
    end
    if (fwd_en && fwd_we) begin
      mem[fwd_addr] <= fwd_wdata;
    end
  end
endmodule // ccsr_far_mem

// ==== dv/test_cpu_core_state_regs.sv ====
// Self-checking bench for the core state block with its memory model.
// Assumes the package compiles first; inputs change on rising edges, except the last irq_ok drop, 1 ns after one.
`timescale 1ns/1ps
module test_cpu_core_state_regs;
  import ccsr_pkg::*;
  localparam logic [15:0] TOP = 16'h08FF;
  localparam int unsigned LIMIT = 3000;
  logic sys_clk = 1'b0;
  logic rst;
  logic fetch_hold, pc_load, instr_valid, ptr_valid, ds_ack, irq_ok;
  logic [15:0] pm_addr, pm_rdata, pc_target, instr_word, opnd_a, ptr_addr;
  logic [7:0] opnd_b, ds_rdata, fwd_wdata, status_flags, irq_req;
  logic fwd_en, fwd_we, irq_take, stk_we, stk_re, stk_two;
  logic [15:0] fwd_addr, stack_top_pointer, stk_addr, stk_wdata;
  logic [4:0] irq_vec;
  ccsr_rd_req_t rd_req;
  ccsr_wr_req_t wr_req;
  ccsr_flag_upd_t flag_upd;
  ccsr_ptr_req_t ptr_req;
  ccsr_ds_req_t ds_req;
  ccsr_ctl_req_t ctl_req;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  ccsr_core_state #(.IRQ_NUM(8), .SP_BITS(16), .SRAM_LAST(TOP)) DUT (
    .sys_clk(sys_clk), .rst(rst), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .fetch_hold(fetch_hold), .pc_load(pc_load), .pc_target(pc_target),
    .instr_word(instr_word), .instr_valid(instr_valid), .rd_req(rd_req),
    .wr_req(wr_req), .flag_upd(flag_upd), .opnd_a(opnd_a), .opnd_b(opnd_b),
    .ptr_req(ptr_req), .ptr_addr(ptr_addr), .ptr_valid(ptr_valid),
    .ds_req(ds_req), .ds_rdata(ds_rdata), .ds_ack(ds_ack), .fwd_en(fwd_en),
    .fwd_we(fwd_we), .fwd_addr(fwd_addr), .fwd_wdata(fwd_wdata),
    .ctl_req(ctl_req), .irq_req(irq_req), .irq_ok(irq_ok),
    .irq_take(irq_take), .irq_vec(irq_vec), .status_flags(status_flags),
    .stack_top_pointer(stack_top_pointer), .stk_we(stk_we),
    .stk_re(stk_re), .stk_two(stk_two), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata));

  ccsr_far_mem u_mem (
    .sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .stk_we(stk_we), .stk_two(stk_two), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .fwd_en(fwd_en), .fwd_we(fwd_we),
    .fwd_addr(fwd_addr), .fwd_wdata(fwd_wdata));

  always #2.5 sys_clk = ~sys_clk;

  task results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang shows up as a timeout rather than a silent stall
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task acc(input ccsr_wr_req_t w, input ccsr_rd_req_t r);
    @(posedge sys_clk);
    wr_req <= w;
    rd_req <= r;
    @(posedge sys_clk);
    wr_req <= '0;
    #1;
  endtask

  task ds(input logic we, input logic io, input logic [15:0] a,
          input logic [7:0] d);
    @(posedge sys_clk);
    ds_req <= '{1'b1, we, io, a, d};
    @(posedge sys_clk);
    ds_req <= '0;
    #1;
  endtask

  task ptr(input logic [1:0] sel, input ccsr_pmode_t m, input logic [5:0] d);
    @(posedge sys_clk);
    ptr_req <= '{1'b1, sel, m, d};
    @(posedge sys_clk);
    ptr_req <= '0;
    #1;
  endtask

  task ctl(input ccsr_op_t o, input logic [4:0] r, input logic [2:0] b,
           input logic [15:0] pc);
    @(posedge sys_clk);
    ctl_req <= '{o, r, b, pc};
    @(posedge sys_clk);
    ctl_req <= '{OP_NONE, 5'h00, 3'h0, 16'h0000};
    #1;
  endtask

  task flg(input logic [7:0] m, input logic [7:0] v);
    @(posedge sys_clk);
    flag_upd <= '{m, v};
    @(posedge sys_clk);
    flag_upd <= '0;
    #1;
  endtask

  task t_fetch();
    logic [15:0] p;
    @(posedge sys_clk);
    #1;
    p = pm_addr;
    @(posedge sys_clk);
    #1;
    chk(instr_word, p ^ 16'hC3C3);
    chk(pm_addr, p + 16'h0001);
    chk(instr_valid, 1'b1);
    @(posedge sys_clk);
    fetch_hold <= 1'b1;
    @(posedge sys_clk);
    #1;
    p = pm_addr;
    @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_target <= 16'h0100;
    #1;
    chk(pm_addr, p);
    @(posedge sys_clk);
    pc_load <= 1'b0;
    fetch_hold <= 1'b0;
    #1;
    chk(pm_addr, 16'h0100);
    chk(instr_valid, 1'b0);
    @(posedge sys_clk);
    #1;
    chk(instr_word, 16'h0100 ^ 16'hC3C3);
  endtask

  task t_regs();
    // Write and read in one cycle exercise the bypass
    acc('{1'b1, 1'b0, 5'd5, 16'h0012}, '{5'd5, 5'd5, 1'b0});
    chk(opnd_a, 16'h0012);
    chk(opnd_b, 8'h12);
    acc('{1'b1, 1'b1, 5'd27, 16'h00FF}, '{5'd26, 5'd27, 1'b1});
    chk(opnd_a, 16'h00FF);
    chk(opnd_b, 8'h00);
    ds(1'b0, 1'b0, 16'h001A, 8'h00);
    chk(ds_ack, 1'b1);
    chk(ds_rdata, 8'hFF);
    ds(1'b1, 1'b0, 16'h0005, 8'h34);
    acc('0, '{5'd5, 5'd0, 1'b0});
    chk(opnd_a, 16'h0034);
  endtask

  task t_ptr();
    ptr(2'd0, PM_INC, 6'h00);
    chk(ptr_addr, 16'h00FF);
    chk(ptr_valid, 1'b1);
    acc('0, '{5'd26, 5'd0, 1'b1});
    chk(opnd_a, 16'h0100);
    ptr(2'd0, PM_DEC, 6'h00);
    chk(ptr_addr, 16'h00FF);
    ptr(2'd0, PM_DISP, 6'h3F);
    chk(ptr_addr, 16'h013E);
    acc('{1'b1, 1'b1, 5'd30, 16'h0000}, '{5'd26, 5'd0, 1'b1});
    chk(opnd_a, 16'h00FF);
    ptr(2'd2, PM_DEC, 6'h00);
    chk(ptr_addr, 16'hFFFF);
    ptr(2'd2, PM_INC, 6'h00);
    acc('0, '{5'd30, 5'd0, 1'b1});
    chk(opnd_a, 16'h0000);
  endtask

  task t_space();
    ds(1'b1, 1'b1, 16'h003F, 8'h0C);
    chk(status_flags, 8'h0C);
    ds(1'b1, 1'b0, 16'h005F, 8'h04);
    chk(status_flags, 8'h14);
    ds(1'b0, 1'b1, 16'h003F, 8'h00);
    chk(ds_rdata, 8'h14);
    ds(1'b1, 1'b1, 16'h0020, 8'hA5);
    chk(fwd_addr, 16'h0040);
    ds(1'b1, 1'b0, 16'h0060, 8'h5A);
    chk(fwd_en, 1'b1);
    chk(ds_ack, 1'b0);
    chk(fwd_we, 1'b1);
    chk(fwd_wdata, 8'h5A);
    @(posedge sys_clk);
    #1;
    chk(u_mem.mem[16'h0060], 8'h5A);
    ds(1'b1, 1'b0, 16'h005F, 8'h00);
  endtask

  task t_flags();
    flg(8'h2F, 8'h2B);
    chk(status_flags, 8'h3B);
    flg(8'h04, 8'h04);
    chk(status_flags, 8'h2F);
    acc('{1'b1, 1'b0, 5'd3, 16'h0004}, '0);
    ctl(OP_BIT_STORE, 5'd3, 3'd2, 16'h0000);
    chk(status_flags, 8'h6F);
    ctl(OP_BIT_LOAD, 5'd7, 3'd5, 16'h0000);
    acc('0, '{5'd7, 5'd0, 1'b0});
    chk(opnd_a, 16'h0020);
    ds(1'b1, 1'b0, 16'h005F, 8'h00);
  endtask

  task t_stack();
    ctl(OP_CALL, 5'd0, 3'd0, 16'h1234);
    chk({stk_we, stk_two}, 2'b11);
    chk(stk_addr, TOP);
    chk(stk_wdata, 16'h1234);
    chk(stack_top_pointer, TOP - 16'h0002);
    ctl(OP_PUSH, 5'd5, 3'd0, 16'h0000);
    chk(u_mem.mem[TOP - 16'h0001], 8'h12);
    chk({stk_we, stk_two}, 2'b10);
    chk(stk_wdata[7:0], 8'h34);
    chk(stack_top_pointer, TOP - 16'h0003);
    ctl(OP_POP, 5'd9, 3'd0, 16'h0000);
    chk(stk_re, 1'b1);
    chk(stk_addr, TOP - 16'h0002);
    chk(stack_top_pointer, TOP - 16'h0002);
    ctl(OP_RET, 5'd0, 3'd0, 16'h0000);
    chk(stk_addr, TOP - 16'h0001);
    // Pop then push back to back: the push must write at the raised top
    @(posedge sys_clk);
    ctl_req <= '{OP_POP, 5'd0, 3'd0, 16'h0000};
    @(posedge sys_clk);
    ctl_req <= '{OP_PUSH, 5'd5, 3'd0, 16'h0000};
    @(posedge sys_clk);
    ctl_req <= '{OP_NONE, 5'h00, 3'h0, 16'h0000};
    #1;
    chk(stk_addr, TOP + 16'h0001);
    chk(stack_top_pointer, TOP);
    ds(1'b0, 1'b0, 16'h005D, 8'h00);
    chk(ds_rdata, TOP[7:0]);
    ds(1'b0, 1'b0, 16'h005E, 8'h00);
    chk(ds_rdata, TOP[15:8]);
  endtask

  task t_irq();
    flg(8'h02, 8'h02);
    @(posedge sys_clk);
    irq_req <= 8'h06;
    irq_ok <= 1'b1;
    repeat (3) begin
      @(posedge sys_clk);
      #1;
      chk(irq_take, 1'b0);
    end
    ctl(OP_IEN_SET, 5'd0, 3'd0, 16'h0000);
    chk(status_flags, 8'h82);
    @(posedge sys_clk);
    irq_req <= '0;
    #1;
    chk(irq_take, 1'b1);
    chk(irq_vec, 5'd1);
    chk(status_flags, 8'h02);
    chk(stack_top_pointer, TOP - 16'h0002);
    ctl(OP_RETURN_FROM_IRQ_OP, 5'd0, 3'd0, 16'h0000);
    chk(status_flags, 8'h82);
    chk(stack_top_pointer, TOP);
    @(posedge sys_clk);
    irq_req <= 8'h05;
    @(posedge sys_clk);
    irq_req <= '0;
    #1;
    chk(irq_take, 1'b1);
    chk(irq_vec, 5'd0);
    chk(status_flags, 8'h02);
    ctl(OP_RETURN_FROM_IRQ_OP, 5'd0, 3'd0, 16'h0000);
    ctl(OP_IEN_CLR, 5'd0, 3'd0, 16'h0000);
    chk(status_flags, 8'h02);
    irq_ok <= 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    fetch_hold = 1'b0;
    pc_load = 1'b0;
    pc_target = 16'h0000;
    rd_req = '0;
    wr_req = '0;
    flag_upd = '0;
    ptr_req = '0;
    ds_req = '0;
    ctl_req = '{OP_NONE, 5'h00, 3'h0, 16'h0000};
    irq_req = '0;
    irq_ok = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(status_flags, STATUS_RST);
    chk(stack_top_pointer, TOP);
    chk(pm_addr, PC_RST);
    @(posedge sys_clk);
    rst <= 1'b0;
    t_fetch();
    t_regs();
    t_ptr();
    t_space();
    t_flags();
    t_stack();
    t_irq();
    results();
  end
endmodule // test_cpu_core_state_regs
